/* File: hdl/uhb_map.vh */
/*
  Constants for the host bus port: register selects, field positions,
  reset values and timing counts.
  Assumes inclusion by bare name from the design files.
*/
`ifndef UHB_MAP_VH
`define UHB_MAP_VH
// Register select codes (address bits, divisor latch access on top)
`define UHB_SEL_RBR_THR 4'h0
`define UHB_SEL_IER     4'h1
`define UHB_SEL_IIR     4'h2
`define UHB_SEL_LCR     4'h3
`define UHB_SEL_MCR     4'h4
`define UHB_SEL_LSR     4'h5
`define UHB_SEL_MSR     4'h6
`define UHB_SEL_SCR     4'h7
`define UHB_LCR_DLA_BIT 7
`define UHB_MCR_CLKSEL_BIT 5
`define UHB_CTRL_RESET  8'h00
`define UHB_LSR_IDLE    8'h60
`define UHB_IIR_IDLE    8'h01
// Crystal frequency in Hz and system clock period in ps
`define UHB_XTAL_HZ     11059200
`define UHB_SYS_PS      4000
`endif

/* File: hdl/uhb_sync.v */
/*
  Three-stage synchroniser for one pin input.
  Assumes the input is asynchronous to sys_clk; out changes only when
  the second and third stages agree.
*/
`timescale 1ns/1ps
`default_nettype none
module uhb_sync #(
  parameter RST_VAL = 1'b1
) (
  input  wire sys_clk,
  input  wire rst_n,
  input  wire din,
  output reg  dout
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

/* File: hdl/uhb_host_port.v */
/*
  Host parallel bus port of the combined modem and serial port.
  Assumes all host pins are asynchronous and are sampled on sys_clk
  (250 MHz); strobes must last well beyond four sampling cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uhb_map.vh"
module uhb_host_port #(
  parameter BAUD_DIV_RST = 16'h0001
) (
  input  wire       sys_clk,
  input  wire       rst_n,
  input  wire       reset_pin,
  input  wire       single_port_select,
  input  wire [3:0] uart_reg_addr,
  input  wire       chip_select_n,
  input  wire       address_strobe_n,
  input  wire       read_strobe_n,
  input  wire       write_strobe_n,
  input  wire [7:0] uart_data_bus_in,
  output reg  [7:0] uart_data_bus_out,
  output reg        uart_data_bus_oe,
  input  wire       crystal_clk_tick,
  input  wire       baud_gen_tick,
  output reg        clk_out,
  output reg        single_port_q,
  output reg  [7:0] modem_reg_q
);
  ////////////////////////////////////////////////////////////////////
  // Every pin passes four flops that filter glitches, so strobes shorter than about two
  // sys_clk periods can be missed; safety from metastability was bought
  // with the no-wait-state speed of the bare pins.
  wire [3:0] addr_s;
  wire [7:0] data_s;
  wire       cs_n_s;
  wire       astb_n_s;
  wire       rd_n_s;
  wire       wr_n_s;
  wire       sp_s;
  wire       rst_s;
  wire       xtal_s;
  wire       baud_s;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_addr
      uhb_sync #(.RST_VAL(1'b0)) u_a (.sys_clk(sys_clk), .rst_n(rst_n),
        .din(uart_reg_addr[gi]), .dout(addr_s[gi]));
    end
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_data
      uhb_sync #(.RST_VAL(1'b0)) u_d (.sys_clk(sys_clk), .rst_n(rst_n),
        .din(uart_data_bus_in[gi]), .dout(data_s[gi]));
    end
  endgenerate
  uhb_sync #(.RST_VAL(1'b1)) u_cs (.sys_clk(sys_clk), .rst_n(rst_n),
    .din(chip_select_n), .dout(cs_n_s));
  uhb_sync #(.RST_VAL(1'b1)) u_astb (.sys_clk(sys_clk), .rst_n(rst_n),
    .din(address_strobe_n), .dout(astb_n_s));
  uhb_sync #(.RST_VAL(1'b1)) u_rd (.sys_clk(sys_clk), .rst_n(rst_n),
    .din(read_strobe_n), .dout(rd_n_s));
  uhb_sync #(.RST_VAL(1'b1)) u_wr (.sys_clk(sys_clk), .rst_n(rst_n),
    .din(write_strobe_n), .dout(wr_n_s));
  uhb_sync #(.RST_VAL(1'b0)) u_sp (.sys_clk(sys_clk), .rst_n(rst_n),
    .din(single_port_select), .dout(sp_s));
  uhb_sync #(.RST_VAL(1'b1)) u_rst (.sys_clk(sys_clk), .rst_n(rst_n),
    .din(reset_pin), .dout(rst_s));
  // Clock sources come from other domains and are resampled like pins
  uhb_sync #(.RST_VAL(1'b0)) u_xtal (.sys_clk(sys_clk), .rst_n(rst_n),
    .din(crystal_clk_tick), .dout(xtal_s));
  uhb_sync #(.RST_VAL(1'b0)) u_baud (.sys_clk(sys_clk), .rst_n(rst_n),
    .din(baud_gen_tick), .dout(baud_s));
  ////////////////////////////////////////////////////////////////////
  // Address strobe capture in single-port mode
  reg       astb_n_q;
  reg [3:0] lat_addr_q;
  reg       lat_cs_n_q;
  reg       wr_n_q;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      astb_n_q   <= 1'b1;
      lat_addr_q <= 4'h0;
      lat_cs_n_q <= 1'b1;
      wr_n_q     <= 1'b1;
    end else begin
      astb_n_q <= astb_n_s;
      wr_n_q   <= wr_n_s;
      if (!astb_n_q && astb_n_s) begin
        lat_addr_q <= addr_s;
        lat_cs_n_q <= cs_n_s;
      end
    end
  end
  // Dual-port mode bypasses the latch and drops the top address bit
  wire [3:0] eff_addr = sp_s ? lat_addr_q : {1'b0, addr_s[2:0]};
  wire       eff_cs_n = sp_s ? lat_cs_n_q : cs_n_s;
  ////////////////////////////////////////////////////////////////////
  reg [7:0] rbr_q;
  reg [7:0] thr_q;
  reg [7:0] dll_q;
  reg [7:0] dlm_q;
  reg [7:0] ier_q;
  reg [7:0] lcr_q;
  reg [7:0] mcr_q;
  reg [7:0] scr_q;
  wire dla = lcr_q[`UHB_LCR_DLA_BIT];
  // Index 8 and 9 stand for the divisor latches, 15 for modem register
  function [3:0] reg_sel;
    input [3:0] a;
    input       d;
    begin
      if (a[3])
        reg_sel = 4'hf;
      else if (d && a[2:0] == 3'd0)
        reg_sel = 4'h8;
      else if (d && a[2:0] == 3'd1)
        reg_sel = 4'h9;
      else
        reg_sel = {1'b0, a[2:0]};
    end
  endfunction
  wire [3:0] sel = reg_sel(eff_addr, dla);
  // Write commits on the strobe's rising edge with chip select active.
  // Data and select pass synchronisers as deep as the strobe's, so they
  // line up with it as long as the host holds them past the edge.
  wire wr_fire = !wr_n_q && wr_n_s && !eff_cs_n && !rst_s;
  // No serial core sits behind this port: the receive buffer mirrors the
  // transmit holding register so software can read back its last byte
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rbr_q <= 8'h00;
      thr_q <= 8'h00;
      dll_q <= BAUD_DIV_RST[7:0];
      dlm_q <= BAUD_DIV_RST[15:8];
    end else begin
      rbr_q <= thr_q;
      if (wr_fire) begin
        case (sel)
          4'h0: thr_q <= data_s;
          4'h8: dll_q <= data_s;
          4'h9: dlm_q <= data_s;
          default: thr_q <= thr_q;
        endcase
      end
    end
  end
  // Control registers cleared by reset pin; data and divisor kept.
  // The reset pin acts four cycles late, as the strobe does, so a write that
  // ends just as reset rises is blocked by rst_s and the clear wins.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ier_q       <= `UHB_CTRL_RESET;
      lcr_q       <= `UHB_CTRL_RESET;
      mcr_q       <= `UHB_CTRL_RESET;
      scr_q       <= `UHB_CTRL_RESET;
      modem_reg_q <= `UHB_CTRL_RESET;
    end else if (rst_s) begin
      ier_q       <= `UHB_CTRL_RESET;
      lcr_q       <= `UHB_CTRL_RESET;
      mcr_q       <= `UHB_CTRL_RESET;
      scr_q       <= `UHB_CTRL_RESET;
      modem_reg_q <= `UHB_CTRL_RESET;
    end else if (wr_fire) begin
      case (sel)
        4'h1: ier_q <= data_s;
        4'h3: lcr_q <= data_s;
        4'h4: mcr_q <= data_s;
        4'h7: scr_q <= data_s;
        4'hf: modem_reg_q <= data_s;
        default: scr_q <= scr_q;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Read path: qualified read only, bus released otherwise
  // Registered data turns the bus around five cycles after the read pin ends
  reg [7:0] rd_mux;
  always @* begin
    case (sel)
      4'h0: rd_mux = rbr_q;
      4'h1: rd_mux = ier_q;
      4'h2: rd_mux = `UHB_IIR_IDLE;
      4'h3: rd_mux = lcr_q;
      4'h4: rd_mux = mcr_q;
      4'h5: rd_mux = `UHB_LSR_IDLE;
      4'h7: rd_mux = scr_q;
      4'h8: rd_mux = dll_q;
      4'h9: rd_mux = dlm_q;
      4'hf: rd_mux = modem_reg_q;
      default: rd_mux = 8'h00;
    endcase
  end
  wire rd_ok = !rd_n_s && !eff_cs_n && !rst_s;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      uart_data_bus_out <= 8'h00;
      uart_data_bus_oe  <= 1'b0;
      clk_out           <= 1'b0;
      single_port_q     <= 1'b0;
    end else begin
      uart_data_bus_oe  <= rd_ok;
      uart_data_bus_out <= rd_ok ? rd_mux : 8'h00;
      single_port_q     <= sp_s;
      // Crystal after reset since the select bit is cleared; the forwarded
      // clock is resampled, so its edges carry one sys_clk period of jitter
      clk_out <= mcr_q[`UHB_MCR_CLKSEL_BIT] ? baud_s : xtal_s;
    end
  end
endmodule
`default_nettype wire

/* File: test/uhb_props.sv */
/* Checker for the host bus port pins.
   Assumes binding into uhb_host_port; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module uhb_props (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       reset_pin,
  input wire logic       single_port_select,
  input wire logic       chip_select_n,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic       crystal_clk_tick,
  input wire logic       uart_data_bus_oe,
  input wire logic       clk_out,
  input wire logic       single_port_q,
  input wire logic [7:0] uart_data_bus_out,
  input wire logic [7:0] modem_reg_q
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  // Windows of eight cover the pin synchronisers plus output flops
  a_idle_bus_zero: assert property (!uart_data_bus_oe |-> uart_data_bus_out == 8'h00)
    else $error("idle bus not zero");
  a_no_read_quiet: assert property (read_strobe_n [*8] |-> !uart_data_bus_oe)
    else $error("bus driven without read");
  a_cs_gates_read: assert property
    ((chip_select_n && !single_port_select) [*8] |-> !uart_data_bus_oe)
    else $error("bus driven without select");
  a_reset_inactive: assert property (reset_pin [*8] |-> !uart_data_bus_oe)
    else $error("bus driven in reset");
  a_reset_clears: assert property (reset_pin [*8] |-> modem_reg_q == 8'h00)
    else $error("control not cleared");
  a_reset_xtal: assert property ((reset_pin && crystal_clk_tick) [*8] |-> clk_out)
    else $error("clock pin not crystal");
  a_write_needed: assert property
    ((write_strobe_n && !reset_pin) [*8] |=> $stable(modem_reg_q))
    else $error("register changed unwritten");
  a_mode_follows: assert property
    ($stable(single_port_select) [*8] |-> single_port_q == single_port_select)
    else $error("mode not followed");
  c_read: cover property ($rose(uart_data_bus_oe));
  c_modem: cover property ($changed(modem_reg_q));
  c_single: cover property ($rose(single_port_q));
endmodule
bind uhb_host_port uhb_props u_uhb_props (
  .sys_clk, .rst_n, .reset_pin, .single_port_select, .chip_select_n, .read_strobe_n,
  .write_strobe_n, .crystal_clk_tick, .uart_data_bus_oe, .clk_out, .single_port_q,
  .uart_data_bus_out, .modem_reg_q
);
`default_nettype wire

/* File: test/uhb_host_model.sv */
/* Host bus master model: strobes, address, select and write data.
   Assumes its pins may change only on the falling edge of sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module uhb_host_model (
  input  wire logic       sys_clk,
  input  wire logic       single_port_select,
  input  wire logic [7:0] bus,
  output var  logic [3:0] uart_reg_addr,
  output var  logic       chip_select_n,
  output var  logic       address_strobe_n,
  output var  logic       read_strobe_n,
  output var  logic       write_strobe_n,
  output var  logic [7:0] host_data
);
  initial begin
    {uart_reg_addr, chip_select_n, address_strobe_n} = 6'h3f;
    {read_strobe_n, write_strobe_n, host_data} = 10'h3ff;
  end
  ////////////////////////////////////////////////////////////
  // In single-port mode address and select are scrambled after the latch edge so a port that ignores the latch fails
  task automatic xfer(input logic w, c, input logic [3:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge sys_clk);
    uart_reg_addr = a;
    chip_select_n = c;
    host_data = d;
    address_strobe_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    address_strobe_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    if (single_port_select) begin
      uart_reg_addr = ~a;
      chip_select_n = ~c;
    end
    if (w) write_strobe_n = 1'b0;
    else read_strobe_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    q = bus;
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    host_data = ~d;
    chip_select_n = 1'b1;
    repeat (8) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

/* File: test/testbench.sv */
/* Self-checking bench for the host bus port.
   Assumes the host model drives the address, select, strobe and data pins; the data bus is resolved here. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       sys_clk = 1'b0, rst_n = 1'b0, reset_pin = 1'b0, xtal = 1'b1, baud = 1'b0;
  logic       single_port_select = 1'b0, chip_select_n, address_strobe_n, read_strobe_n;
  logic       write_strobe_n, uart_data_bus_oe, clk_out, single_port_q;
  logic [3:0] uart_reg_addr;
  logic [7:0] host_data, uart_data_bus_out, modem_reg_q, q;
  wire  [7:0] bus = uart_data_bus_oe ? uart_data_bus_out : host_data;
  int         fails = 0, tests_run = 0, cycles = 0;
  always #2 sys_clk = ~sys_clk;
  uhb_host_model u_uhb_host_model (.sys_clk, .single_port_select, .bus, .uart_reg_addr,
    .chip_select_n, .address_strobe_n, .read_strobe_n, .write_strobe_n, .host_data);
  uhb_host_port u_uhb_host_port (.sys_clk, .rst_n, .reset_pin, .single_port_select,
    .uart_reg_addr, .chip_select_n, .address_strobe_n, .read_strobe_n, .write_strobe_n,
    .uart_data_bus_in(bus), .uart_data_bus_out, .uart_data_bus_oe,
    .crystal_clk_tick(xtal), .baud_gen_tick(baud), .clk_out, .single_port_q, .modem_reg_q);
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Both sources are swapped so a clock pin stuck at one level cannot pass
  task automatic src_chk(input logic b);
    @(negedge sys_clk);
    {xtal, baud} = 2'b01;
    repeat (6) @(negedge sys_clk);
    chk({7'h00, clk_out}, {7'h00, b});
    {xtal, baud} = 2'b10;
    repeat (6) @(negedge sys_clk);
    chk({7'h00, clk_out}, {7'h00, !b});
  endtask
  task automatic wr(input logic c, input logic [3:0] a, input logic [7:0] d);
    u_uhb_host_model.xfer(1'b1, c, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a);
    u_uhb_host_model.xfer(1'b0, 1'b0, a, 8'h00, q);
  endtask
  task automatic t_dual;
    wr(1'b0, 4'hf, 8'ha5);
    chk(modem_reg_q, 8'h00);
    rd(4'h7);
    chk(q, 8'ha5);
    wr(1'b1, 4'h7, 8'h3c);
    rd(4'h7);
    chk(q, 8'ha5);
    u_uhb_host_model.xfer(1'b0, 1'b1, 4'h7, 8'h00, q);
    chk(q, 8'h00);
    wr(1'b0, 4'h0, 8'h5c);
    rd(4'h0);
    chk(q, 8'h5c);
  endtask
  task automatic t_reset;
    wr(1'b0, 4'h3, 8'h80);
    wr(1'b0, 4'h0, 8'h5a);
    wr(1'b0, 4'h4, 8'h20);
    src_chk(1'b1);
    @(negedge sys_clk);
    reset_pin = 1'b1;
    repeat (10) @(negedge sys_clk);
    chk({6'h00, clk_out, uart_data_bus_oe}, 8'h02);
    reset_pin = 1'b0;
    rd(4'h3);
    chk(q, 8'h00);
    wr(1'b0, 4'h3, 8'h80);
    rd(4'h0);
    chk(q, 8'h5a);
    wr(1'b0, 4'h3, 8'h00);
    rd(4'h0);
    chk(q, 8'h5c);
  endtask
  // Latched select high with the pin low must still refuse the write
  task automatic t_single;
    @(negedge sys_clk);
    single_port_select = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk({7'h00, single_port_q}, 8'h01);
    wr(1'b0, 4'h8, 8'hc3);
    chk(modem_reg_q, 8'hc3);
    wr(1'b1, 4'h8, 8'h11);
    chk(modem_reg_q, 8'hc3);
    wr(1'b0, 4'h7, 8'h66);
    rd(4'h7);
    chk(q, 8'h66);
  endtask
  task automatic final_report;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    src_chk(1'b0);
    t_dual();
    t_reset();
    t_single();
    final_report();
  end
endmodule
`default_nettype wire
